// File: rscl_pkg.sv
package rscl_pkg;

  // ****************************************
  // Special register addresses
  // ****************************************
  localparam logic [7:0] ADDR_POWER_MODE_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_DATA_BASE_HIGH = 8'h9c;
  localparam logic [7:0] ADDR_CHIP_CONTROL = 8'h9f;
  localparam logic [7:0] ADDR_POWER_MONITOR_CONTROL = 8'ha3;
  localparam logic [7:0] ADDR_FLASH_PROGRAM_TRIGGER = 8'ha4;
  localparam logic [7:0] ADDR_WATCHDOG_RESET_ENABLE = 8'hab;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'hd8;
  localparam logic [7:0] ADDR_TIMED_ACCESS = 8'hc7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_CFG_BOOT_SOURCE = 7;
  localparam int BIT_CFG_READ_UNLOCK = 1;
  localparam int BIT_CFG_DATA_DISABLE = 0;
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_BOOT_SELECT = 1;
  localparam int BIT_WATCHDOG_RUN = 7;

  // ****************************************
  // Reset values and keys
  // ****************************************
  localparam logic [15:0] RST_PROGRAM_COUNTER = 16'h0000;
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_PORT_LATCH = 8'hff;
  localparam logic [7:0] CFG_ERASED = 8'hff;
  localparam logic [7:0] LOCKED_READ = 8'hff;
  localparam logic [7:0] KEY_FIRST = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam logic [1:0] KEY_WINDOW = 2'h3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] FLASH_TOP = 16'h4000;
  localparam logic [15:0] MIN_PROGRAM_SIZE = 16'h0100;

  // Reset source coding
  typedef enum logic [1:0] {
    RSCL_SRC_POWER_ON,
    RSCL_SRC_EXTERNAL,
    RSCL_SRC_WATCHDOG,
    RSCL_SRC_SOFTWARE
  } rscl_source_type;

  // Sequencer states
  typedef enum logic [1:0] {
    RSCL_ST_HOLD,
    RSCL_ST_LOAD,
    RSCL_ST_RUN
  } rscl_state_type;

endpackage

// File: rscl_key_if.sv
`timescale 1ns/1ps
// Carries register writes into the timed-access unit and its verdict back
interface rscl_key_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic open;

  modport core (output wr_en, output wr_addr, output wr_data, input open);
  modport key (input wr_en, input wr_addr, input wr_data, output open);
endinterface : rscl_key_if

// File: rscl_timed_access.sv
`timescale 1ns/1ps
module rscl_timed_access (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_machine_cycle,
  rscl_key_if.key bus
);

  typedef enum logic [1:0] {
    RSCL_KEY_IDLE,
    RSCL_KEY_ARMED,
    RSCL_KEY_OPEN
  } rscl_key_state_type;

  rscl_key_state_type state_reg, state_next;
  logic [1:0] gap_reg, gap_next;
  logic key_write;

  assign key_write = bus.wr_en && (bus.wr_addr == rscl_pkg::ADDR_TIMED_ACCESS);

  // ****************************************
  // Two-write unlock sequencer
  // ****************************************
  // Unlock lasts until the next register write, whatever its address
  always_comb begin
    state_next = state_reg;
    gap_next = gap_reg;
    case (state_reg)
      RSCL_KEY_IDLE: begin
        if (key_write && bus.wr_data == rscl_pkg::KEY_FIRST) begin
          state_next = RSCL_KEY_ARMED;
          gap_next = 2'h0;
        end
      end
      RSCL_KEY_ARMED: begin
        if (key_write && bus.wr_data == rscl_pkg::KEY_SECOND) begin
          state_next = RSCL_KEY_OPEN;
        end else if (bus.wr_en || gap_reg == rscl_pkg::KEY_WINDOW) begin
          state_next = RSCL_KEY_IDLE;
        end else if (i_machine_cycle) begin
          gap_next = gap_reg + 2'h1;
        end
      end
      RSCL_KEY_OPEN: begin
        if (bus.wr_en) begin
          state_next = RSCL_KEY_IDLE;
        end
      end
      default: begin
        state_next = RSCL_KEY_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= RSCL_KEY_IDLE;
      gap_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      gap_reg <= gap_next;
    end
  end

  assign bus.open = (state_reg == RSCL_KEY_OPEN);

endmodule // rscl_timed_access

// File: rscl_loader.sv
`timescale 1ns/1ps
// Function
// - Reset never clears or alters data RAM contents.
// - Program counter held at zero during reset; fetch starts there.
// - Stack pointer loads seven on every reset.
// - All interrupts disabled and all timers stopped after reset.
// - Watchdog left disabled after power-on reset.
// - Every port output register loads all ones on reset.
// - Protected write needs AA then 55 within three machine cycles.
// - Config bytes copied to shadows; soft reset skips boot-source bit.
// - Shadow bits other than the data-region disable bit stay software writable after loading.
// - Boot-source bit one selects application flash, zero loader flash.
// - Locked chip returns all ones on programmer flash reads.
// - Boot-lock config byte always readable; config not individually programmable while locked.
// - Only whole-chip erase clears lock, erasing everything else too.
// - Lock does not restrict firmware in-system programming.
// - Disable bit one gives full application flash; zero shares it.
// - Base byte is data region high address, used only when enabled.
// - Base zero leaves no application flash; run 256-byte minimum.
// - Unprogrammed configuration byte reads all ones.
// - Non-soft resets load boot select with inverted boot-source bit.
// - Boot flash picked from run-time boot select bit.
// - Soft reset bit starts system reset; hardware clears it.
module rscl_loader (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_power_on_reset,
  input wire logic i_external_reset,
  input wire logic i_watchdog_reset,
  input wire logic i_machine_cycle,
  input wire logic [7:0] i_boot_lock_config_byte,
  input wire logic [7:0] i_data_flash_base_config_byte,
  input wire logic i_cfg_watchdog_enable,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic i_prog_rd,
  input wire logic i_prog_cfg_sel,
  input wire logic [7:0] i_prog_flash_data,
  input wire logic i_prog_cfg_write,
  input wire logic i_prog_chip_erase,
  input wire logic i_isp_write,
  output logic [7:0] o_sfr_rdata,
  output logic [7:0] o_prog_rdata,
  output logic o_prog_cfg_write_ok,
  output logic o_prog_erase_all,
  output logic o_isp_write_ok,
  output logic o_cpu_reset,
  output logic [15:0] o_program_counter,
  output logic [7:0] o_stack_pointer,
  output logic o_interrupts_enabled,
  output logic o_timers_run,
  output logic [7:0] o_port_latch,
  output logic o_boot_from_loader,
  output logic o_watchdog_run_enable,
  output logic o_data_region_enable,
  output logic [15:0] o_data_region_start,
  output logic [15:0] o_application_limit
);

  // ****************************************
  // State
  // ****************************************
  rscl_pkg::rscl_state_type state_reg, state_next;
  rscl_pkg::rscl_source_type source_reg, source_next;
  logic [7:0] chip_control_reg, chip_control_next;
  logic [7:0] data_region_base_shadow_reg, data_region_base_shadow_next;
  logic [7:0] watchdog_control_reg, watchdog_control_next;
  logic [7:0] watchdog_reset_enable_reg, watchdog_reset_enable_next;
  logic data_region_disable_reg, data_region_disable_next;
  logic [7:0] sfr_rdata_reg, sfr_rdata_next;
  logic [7:0] prog_rdata_reg, prog_rdata_next;
  logic [5:0] flags_reg, flags_next;
  logic [15:0] start_reg, start_next;
  logic [15:0] limit_reg, limit_next;
  logic boot_from_loader;
  logic sys_reset;
  logic protected_ok;
  logic read_unlocked;

  rscl_key_if key_bus ();

  assign key_bus.wr_en = i_sfr_wr;
  assign key_bus.wr_addr = i_sfr_addr;
  assign key_bus.wr_data = i_sfr_wdata;
  assign protected_ok = key_bus.open;

  // ****************************************
  // Timed-access unit
  // ****************************************
  rscl_timed_access u_key (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_machine_cycle(i_machine_cycle),
    .bus(key_bus.key)
  );

  // Any reset source, soft reset included, holds the core
  assign sys_reset = i_power_on_reset || i_external_reset || i_watchdog_reset
    || chip_control_reg[rscl_pkg::BIT_SOFT_RESET];
  assign read_unlocked = i_boot_lock_config_byte[rscl_pkg::BIT_CFG_READ_UNLOCK];
  assign boot_from_loader = chip_control_reg[rscl_pkg::BIT_BOOT_SELECT];

  // ****************************************
  // Reset sequencing and shadow loading
  // ****************************************
  // no RAM is held here, so reset never touches stored words
  always_comb begin
    state_next = state_reg;
    source_next = source_reg;
    chip_control_next = chip_control_reg;
    data_region_base_shadow_next = data_region_base_shadow_reg;
    watchdog_control_next = watchdog_control_reg;
    watchdog_reset_enable_next = watchdog_reset_enable_reg;
    data_region_disable_next = data_region_disable_reg;
    case (state_reg)
      rscl_pkg::RSCL_ST_HOLD: begin
        // Remember the strongest source; power-on outranks the rest
        if (i_power_on_reset) begin
          source_next = rscl_pkg::RSCL_SRC_POWER_ON;
        end else if (i_watchdog_reset) begin
          source_next = rscl_pkg::RSCL_SRC_WATCHDOG;
        end else if (i_external_reset) begin
          source_next = rscl_pkg::RSCL_SRC_EXTERNAL;
        end
        if (!sys_reset) begin
          state_next = rscl_pkg::RSCL_ST_LOAD;
        end
      end
      rscl_pkg::RSCL_ST_LOAD: begin
        data_region_base_shadow_next = i_data_flash_base_config_byte;
        data_region_disable_next = i_boot_lock_config_byte[rscl_pkg::BIT_CFG_DATA_DISABLE];
        watchdog_reset_enable_next = rscl_pkg::ZERO_BYTE;
        if (source_reg != rscl_pkg::RSCL_SRC_SOFTWARE) begin
          chip_control_next[rscl_pkg::BIT_BOOT_SELECT] =
            !i_boot_lock_config_byte[rscl_pkg::BIT_CFG_BOOT_SOURCE];
        end
        if (source_reg == rscl_pkg::RSCL_SRC_POWER_ON) begin
          watchdog_control_next = rscl_pkg::ZERO_BYTE;
        end else begin
          watchdog_control_next[rscl_pkg::BIT_WATCHDOG_RUN] = i_cfg_watchdog_enable;
        end
        state_next = rscl_pkg::RSCL_ST_RUN;
      end
      rscl_pkg::RSCL_ST_RUN: begin
        if (i_sfr_wr && protected_ok) begin
          case (i_sfr_addr)
            rscl_pkg::ADDR_CHIP_CONTROL: chip_control_next = i_sfr_wdata;
            rscl_pkg::ADDR_DATA_BASE_HIGH: data_region_base_shadow_next = i_sfr_wdata;
            rscl_pkg::ADDR_WATCHDOG_CONTROL: watchdog_control_next = i_sfr_wdata;
            rscl_pkg::ADDR_WATCHDOG_RESET_ENABLE: watchdog_reset_enable_next = i_sfr_wdata;
            default: ;
          endcase
        end
        if (chip_control_reg[rscl_pkg::BIT_SOFT_RESET]) begin
          source_next = rscl_pkg::RSCL_SRC_SOFTWARE;
          chip_control_next[rscl_pkg::BIT_SOFT_RESET] = 1'b0;
          state_next = rscl_pkg::RSCL_ST_HOLD;
        end
        if (i_power_on_reset || i_external_reset || i_watchdog_reset) begin
          state_next = rscl_pkg::RSCL_ST_HOLD;
        end
      end
      default: begin
        state_next = rscl_pkg::RSCL_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= rscl_pkg::RSCL_ST_HOLD;
      source_reg <= rscl_pkg::RSCL_SRC_POWER_ON;
      chip_control_reg <= rscl_pkg::ZERO_BYTE;
      data_region_base_shadow_reg <= rscl_pkg::CFG_ERASED;
      watchdog_control_reg <= rscl_pkg::ZERO_BYTE;
      watchdog_reset_enable_reg <= rscl_pkg::ZERO_BYTE;
      data_region_disable_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      source_reg <= source_next;
      chip_control_reg <= chip_control_next;
      data_region_base_shadow_reg <= data_region_base_shadow_next;
      watchdog_control_reg <= watchdog_control_next;
      watchdog_reset_enable_reg <= watchdog_reset_enable_next;
      data_region_disable_reg <= data_region_disable_next;
    end
  end

  // ****************************************
  // Read paths and memory map
  // ****************************************
  always_comb begin
    sfr_rdata_next = sfr_rdata_reg;
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        rscl_pkg::ADDR_CHIP_CONTROL: sfr_rdata_next = chip_control_reg;
        rscl_pkg::ADDR_DATA_BASE_HIGH: sfr_rdata_next = data_region_base_shadow_reg;
        rscl_pkg::ADDR_WATCHDOG_CONTROL: sfr_rdata_next = watchdog_control_reg;
        rscl_pkg::ADDR_WATCHDOG_RESET_ENABLE: sfr_rdata_next = watchdog_reset_enable_reg;
        default: sfr_rdata_next = rscl_pkg::ZERO_BYTE;
      endcase
    end
    prog_rdata_next = prog_rdata_reg;
    if (i_prog_rd) begin
      if (i_prog_cfg_sel) begin
        prog_rdata_next = i_boot_lock_config_byte;
      end else if (!read_unlocked) begin
        prog_rdata_next = rscl_pkg::LOCKED_READ;
      end else begin
        prog_rdata_next = i_prog_flash_data;
      end
    end
    flags_next[0] = i_prog_cfg_write && read_unlocked;
    flags_next[1] = i_prog_chip_erase;
    flags_next[2] = i_isp_write;
    flags_next[3] = (state_reg != rscl_pkg::RSCL_ST_RUN) || sys_reset;
    flags_next[4] = boot_from_loader;
    // Registered so the enable lines up with start and limit
    flags_next[5] = !data_region_disable_reg;
    if (data_region_disable_reg) begin
      start_next = rscl_pkg::FLASH_TOP;
      limit_next = rscl_pkg::FLASH_TOP;
    end else if (data_region_base_shadow_reg == rscl_pkg::ZERO_BYTE) begin
      start_next = rscl_pkg::RST_PROGRAM_COUNTER;
      limit_next = rscl_pkg::MIN_PROGRAM_SIZE;
    end else begin
      start_next = {data_region_base_shadow_reg, rscl_pkg::ZERO_BYTE};
      limit_next = {data_region_base_shadow_reg, rscl_pkg::ZERO_BYTE};
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sfr_rdata_reg <= rscl_pkg::ZERO_BYTE;
      prog_rdata_reg <= rscl_pkg::LOCKED_READ;
      flags_reg <= 6'h08;
      start_reg <= rscl_pkg::FLASH_TOP;
      limit_reg <= rscl_pkg::FLASH_TOP;
    end else begin
      sfr_rdata_reg <= sfr_rdata_next;
      prog_rdata_reg <= prog_rdata_next;
      flags_reg <= flags_next;
      start_reg <= start_next;
      limit_reg <= limit_next;
    end
  end

  // ****************************************
  // Core reset values
  // ****************************************
  // Reset images are constants; the core adopts them while held
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_program_counter <= rscl_pkg::RST_PROGRAM_COUNTER;
      o_stack_pointer <= rscl_pkg::RST_STACK_POINTER;
      o_interrupts_enabled <= 1'b0;
      o_timers_run <= 1'b0;
      o_port_latch <= rscl_pkg::RST_PORT_LATCH;
    end else begin
      o_program_counter <= rscl_pkg::RST_PROGRAM_COUNTER;
      o_stack_pointer <= rscl_pkg::RST_STACK_POINTER;
      o_interrupts_enabled <= 1'b0;
      o_timers_run <= 1'b0;
      o_port_latch <= rscl_pkg::RST_PORT_LATCH;
    end
  end

  assign o_sfr_rdata = sfr_rdata_reg;
  assign o_prog_rdata = prog_rdata_reg;
  assign o_prog_cfg_write_ok = flags_reg[0];
  assign o_prog_erase_all = flags_reg[1];
  assign o_isp_write_ok = flags_reg[2];
  assign o_cpu_reset = flags_reg[3];
  assign o_boot_from_loader = flags_reg[4];
  assign o_watchdog_run_enable = watchdog_control_reg[rscl_pkg::BIT_WATCHDOG_RUN];
  assign o_data_region_enable = flags_reg[5];
  assign o_data_region_start = start_reg;
  assign o_application_limit = limit_reg;

endmodule // rscl_loader

// File: rscl_cfg_store.sv
`timescale 1ns/1ps
// ****************************************
// Configuration storage facing the loader
// ****************************************
module rscl_cfg_store (
  input wire logic i_clock,
  input wire logic i_grant_write,
  input wire logic i_grant_erase,
  input wire logic [7:0] i_new_boot,
  input wire logic [7:0] i_new_base,
  input wire logic i_new_wdt,
  output logic [7:0] o_boot_byte,
  output logic [7:0] o_base_byte,
  output logic o_wdt_enable
);
  logic [7:0] boot_q = 8'hff;
  logic [7:0] base_q = 8'hff;
  logic wdt_q = 1'b1;

  // Only granted requests land, so a locked part keeps its bytes until a chip erase
  // erase first, then grant, reserved bits forced to one
  always @(posedge i_clock) begin
    if (i_grant_erase) begin
      boot_q <= 8'hff;
      base_q <= 8'hff;
      wdt_q <= 1'b1;
    end else if (i_grant_write) begin
      boot_q <= i_new_boot | 8'h7c;
      base_q <= i_new_base;
      wdt_q <= i_new_wdt;
    end
  end

  // Watchdog level goes out already inverted
  assign o_boot_byte = boot_q;
  assign o_base_byte = base_q;
  assign o_wdt_enable = ~wdt_q;
endmodule // rscl_cfg_store

// File: rscl_loader_sva.sv
`timescale 1ns/1ps
// ****************************************
// Port relations of the reset loader
// ****************************************
module rscl_loader_sva (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [7:0] i_boot_lock_config_byte,
  input wire logic i_prog_rd,
  input wire logic i_prog_cfg_sel,
  input wire logic i_prog_cfg_write,
  input wire logic i_prog_chip_erase,
  input wire logic i_isp_write,
  input wire logic [7:0] o_prog_rdata,
  input wire logic o_prog_cfg_write_ok,
  input wire logic o_prog_erase_all,
  input wire logic o_isp_write_ok,
  input wire logic o_cpu_reset,
  input wire logic [15:0] o_program_counter,
  input wire logic [7:0] o_stack_pointer,
  input wire logic o_interrupts_enabled,
  input wire logic o_timers_run,
  input wire logic o_data_region_enable,
  input wire logic [15:0] o_data_region_start,
  input wire logic [15:0] o_application_limit
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // Core image while held and at release
  a_pc_at_zero: assert property (o_cpu_reset |-> o_program_counter == 16'h0000)
    else $error("program counter off zero in reset");
  a_sp_seven: assert property ($fell(o_cpu_reset) |-> o_stack_pointer == 8'h07)
    else $error("stack pointer not seven at release");
  a_quiet_start: assert property ($fell(o_cpu_reset) |-> !o_interrupts_enabled && !o_timers_run)
    else $error("interrupts or timers live at release");
  a_load_first: assert property ($fell(o_cpu_reset) |-> o_data_region_enable == !i_boot_lock_config_byte[0])
    else $error("region shadow not loaded at release");

  // Programmer side gating; reads and config writes follow the live lock bit
  a_locked_ones: assert property (i_prog_rd && !i_prog_cfg_sel && !i_boot_lock_config_byte[1]
    |=> o_prog_rdata == 8'hff) else $error("locked flash read not all ones");
  a_cfg_gate: assert property (i_prog_cfg_write |=> o_prog_cfg_write_ok == $past(i_boot_lock_config_byte[1]))
    else $error("config write grant wrong for lock state");
  a_erase_grant: assert property (i_prog_chip_erase |=> o_prog_erase_all)
    else $error("chip erase not granted");
  a_isp_free: assert property (i_isp_write |=> o_isp_write_ok)
    else $error("firmware write refused");

  // Flash split
  a_full_flash: assert property (!o_data_region_enable |-> o_application_limit == 16'h4000)
    else $error("limit not full flash without data region");
  a_base_zero: assert property (o_data_region_enable && o_data_region_start == 16'h0000
    |-> o_application_limit == 16'h0100) else $error("zero base limit not minimum region");
endmodule // rscl_loader_sva

// File: rscl_loader_test.sv
`timescale 1ns/1ps
bind rscl_loader rscl_loader_sva i_sva (.i_clock, .i_rst_n, .i_boot_lock_config_byte,
  .i_prog_rd, .i_prog_cfg_sel, .i_prog_cfg_write, .i_prog_chip_erase, .i_isp_write,
  .o_prog_rdata, .o_prog_cfg_write_ok, .o_prog_erase_all, .o_isp_write_ok, .o_cpu_reset,
  .o_program_counter, .o_stack_pointer, .o_interrupts_enabled, .o_timers_run,
  .o_data_region_enable, .o_data_region_start, .o_application_limit);

module rscl_loader_test;
  // ****************************************
  // Signals, model and tasks
  // ****************************************
  logic i_clock, i_rst_n, i_power_on_reset, i_external_reset, i_machine_cycle, i_sfr_wr;
  logic i_sfr_rd, i_prog_rd, i_prog_cfg_write, i_prog_chip_erase, i_isp_write, new_wdt, wdt_en;
  logic [7:0] i_sfr_addr, i_sfr_wdata, i_prog_flash_data, new_boot, new_base, boot_b, base_b, r;
  logic [7:0] o_sfr_rdata, o_prog_rdata, o_stack_pointer, o_port_latch, mc_cnt = 8'h00;
  logic [15:0] o_program_counter, o_data_region_start, o_application_limit;
  logic o_prog_cfg_write_ok, o_prog_erase_all, o_isp_write_ok, o_cpu_reset, o_interrupts_enabled;
  logic o_timers_run, o_boot_from_loader, o_watchdog_run_enable, o_data_region_enable;
  logic [31:0] lfsr;
  logic i_watchdog_reset, i_prog_cfg_sel;
  int err_count = 0, tests_run = 0, m_bs, m_wdt, m_base, m_dis, c_boot, c_base, c_wdt;

  rscl_loader i_dut (.i_clock, .i_rst_n, .i_power_on_reset, .i_external_reset,
    .i_watchdog_reset, .i_machine_cycle, .i_boot_lock_config_byte(boot_b),
    .i_data_flash_base_config_byte(base_b), .i_cfg_watchdog_enable(wdt_en), .i_sfr_wr,
    .i_sfr_addr, .i_sfr_wdata, .i_sfr_rd, .i_prog_rd, .i_prog_cfg_sel,
    .i_prog_flash_data, .i_prog_cfg_write, .i_prog_chip_erase, .i_isp_write, .o_sfr_rdata,
    .o_prog_rdata, .o_prog_cfg_write_ok, .o_prog_erase_all, .o_isp_write_ok, .o_cpu_reset,
    .o_program_counter, .o_stack_pointer, .o_interrupts_enabled, .o_timers_run, .o_port_latch,
    .o_boot_from_loader, .o_watchdog_run_enable, .o_data_region_enable, .o_data_region_start,
    .o_application_limit);

  rscl_cfg_store i_store (.i_clock, .i_grant_write(o_prog_cfg_write_ok),
    .i_grant_erase(o_prog_erase_all), .i_new_boot(new_boot), .i_new_base(new_base),
    .i_new_wdt(new_wdt), .o_boot_byte(boot_b), .o_base_byte(base_b), .o_wdt_enable(wdt_en));

  // Free-running clock, 50 ns period
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // Machine cycle strobe every fourth clock
  always @(posedge i_clock) begin
    mc_cnt <= mc_cnt + 8'h01;
    #2 i_machine_cycle = (mc_cnt[1:0] == 2'b00);
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask

  // Write held one edge; keep leaves the strobe up for a chained write
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d, input bit keep);
    i_sfr_wr = 1'b1;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    tick(1);
    if (!keep) i_sfr_wr = 1'b0;
  endtask

  task automatic prot_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_wr(rscl_pkg::ADDR_TIMED_ACCESS, rscl_pkg::KEY_FIRST, 1'b1);
    sfr_wr(rscl_pkg::ADDR_TIMED_ACCESS, rscl_pkg::KEY_SECOND, 1'b1);
    sfr_wr(a, d, 1'b0);
  endtask

  task automatic sfr_rd(input logic [7:0] a);
    i_sfr_rd = 1'b1;
    i_sfr_addr = a;
    tick(1);
    i_sfr_rd = 1'b0;
    r = o_sfr_rdata;
  endtask

  // Programmer requests: 0 read, 1 config write, 2 erase, 4 config read, other firmware write
  task automatic prog(input int k);
    case (k)
      0: i_prog_rd = 1'b1;
      4: {i_prog_rd, i_prog_cfg_sel} = 2'b11;
      1: i_prog_cfg_write = 1'b1;
      2: i_prog_chip_erase = 1'b1;
      default: i_isp_write = 1'b1;
    endcase
    tick(1);
    {i_prog_rd, i_prog_cfg_sel, i_prog_cfg_write, i_prog_chip_erase, i_isp_write} = 5'h00;
  endtask

  // Reset outcome by source: 0 power-on, 1 external, 2 watchdog, 3 software
  // reload by source
  task automatic wait_run(input int src);
    int n;
    n = 0;
    while (o_cpu_reset !== 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
    if (o_cpu_reset !== 1'b0) begin
      err_count++;
      $display("[FAIL] core release expected 0 seen 1");
      final_report;
    end
    m_base = c_base;
    m_dis = c_boot & 1;
    if (src != 3) m_bs = 1 - c_boot[7];
    m_wdt = (src == 0) ? 0 : 1 - c_wdt;
  endtask

  task automatic por;
    i_rst_n = 1'b0;
    i_power_on_reset = 1'b1;
    tick(2);
    i_rst_n = 1'b1;
    tick(1);
    i_power_on_reset = 1'b0;
    wait_run(0);
  endtask

  task automatic chk_state;
    int st;
    st = m_dis ? 'h4000 : m_base << 8;
    check("pc", o_program_counter, 16'h0000);
    check("sp", o_stack_pointer, 16'h0007);
    check("irq timers", {o_interrupts_enabled, o_timers_run}, 16'h0000);
    check("ports", o_port_latch, 16'h00ff);
    check("boot select", o_boot_from_loader, 16'(m_bs));
    check("watchdog", o_watchdog_run_enable, 16'(m_wdt));
    check("region on", o_data_region_enable, 16'(!m_dis));
    check("region start", o_data_region_start, 16'(st));
    check("limit", o_application_limit, (!m_dis && m_base == 0) ? 16'h0100 : 16'(st));
    sfr_rd(rscl_pkg::ADDR_DATA_BASE_HIGH);
    check("base shadow", r, 16'(m_base));
    sfr_rd(rscl_pkg::ADDR_CHIP_CONTROL);
    check("chip control", {r[7], r[1]}, 16'(m_bs));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {i_rst_n, i_power_on_reset, i_external_reset, i_watchdog_reset, i_sfr_wr, i_sfr_rd} = 6'h00;
    {i_prog_rd, i_prog_cfg_sel, i_prog_cfg_write, i_prog_chip_erase, i_isp_write, new_wdt} = 6'h00;
    {i_sfr_addr, i_sfr_wdata, i_prog_flash_data, new_boot, new_base} = 40'h0;
    lfsr = 32'h0000_a70c;
    c_boot = 'hff;
    c_base = 'hff;
    c_wdt = 1;
    m_bs = 0;
    por;
    chk_state;
    sfr_rd(rscl_pkg::ADDR_WATCHDOG_RESET_ENABLE);
    check("wdt reset enable", r, 16'h0000);
    $display("test power-on done");
    // Program boot from loader, data region at a random base, watchdog on
    lfsr = lfsr_next(lfsr);
    i_prog_flash_data = lfsr[7:0];
    prog(0);
    check("open read", o_prog_rdata, i_prog_flash_data);
    lfsr = lfsr_next(lfsr);
    new_base = {2'b00, lfsr[5:0] | 6'h01};
    new_boot = 8'h02;
    prog(1);
    check("cfg grant", o_prog_cfg_write_ok, 16'h0001);
    tick(1);
    c_boot = 'h7e;
    c_base = new_base;
    c_wdt = 0;
    por;
    chk_state;
    $display("test config load done");
    prot_wr(rscl_pkg::ADDR_DATA_BASE_HIGH, 8'h00);
    m_base = 0;
    tick(2);
    chk_state;
    sfr_wr(rscl_pkg::ADDR_TIMED_ACCESS, rscl_pkg::KEY_FIRST, 1'b0);
    tick(16);
    sfr_wr(rscl_pkg::ADDR_TIMED_ACCESS, rscl_pkg::KEY_SECOND, 1'b1);
    sfr_wr(rscl_pkg::ADDR_DATA_BASE_HIGH, 8'h33, 1'b0);
    chk_state;
    $display("test timed access done");
    // software reset keeps written boot select
    prot_wr(rscl_pkg::ADDR_CHIP_CONTROL, 8'h80);
    m_bs = 0;
    tick(3);
    wait_run(3);
    chk_state;
    $display("test software reset done");
    // Lock, then only whole erase reopens the part
    new_boot = 8'h00;
    prog(1);
    tick(1);
    c_boot = 'h7c;
    prog(0);
    check("locked read", o_prog_rdata, 16'h00ff);
    prog(4);
    check("locked cfg read", o_prog_rdata, 16'(c_boot));
    prog(1);
    check("locked cfg grant", o_prog_cfg_write_ok, 16'h0000);
    prog(3);
    check("isp grant", o_isp_write_ok, 16'h0001);
    prog(2);
    check("erase grant", o_prog_erase_all, 16'h0001);
    tick(1);
    c_boot = 'hff;
    c_base = 'hff;
    c_wdt = 1;
    prog(0);
    check("erased read", o_prog_rdata, i_prog_flash_data);
    $display("test lock done");
    // External, then watchdog reset reload boot select from the erased byte
    for (int s = 1; s < 3; s++) begin
      {i_watchdog_reset, i_external_reset} = 2'(s);
      tick(3);
      {i_watchdog_reset, i_external_reset} = 2'b00;
      wait_run(s);
      chk_state;
      $display("test external or watchdog reset done");
    end
    final_report;
  end
endmodule // rscl_loader_test
